// >>> dv/port_events_model.sv
`timescale 1ns/1ns

// =============================================
// Phy, link and transport event source
module port_events_model
(
   input  wire logic                  aclk,
   output sata_err_pkg::port_events_t events
);
   // Levels persist between pulses; pulses ride on top of them
   sata_err_pkg::port_events_t levels;

   initial
   begin
      levels = '0;
      events = '0;
   end

   task automatic pulse(input sata_err_pkg::port_events_t v, input int n);
      @(posedge aclk);
      events <= v | levels;
      repeat (n) @(posedge aclk);
      events <= levels;
   endtask

   task automatic set_levels(input logic up, input logic await_init);
      @(posedge aclk);
      levels.phy_ready = up;
      levels.host_await_cominit = await_init;
      events <= levels;
   endtask
endmodule // port_events_model

// >>> dv/sata_err_status_asserts.sv
`timescale 1ns/1ns
`include "sata_err_params.svh"

// =============================================
// Bus timing and flag side-effect checks
module sata_err_status_asserts
#(
   parameter int ADDR_W = 8
)
(
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic [ADDR_W-1:0]          awaddr,
   input wire logic                       awvalid,
   input wire logic                       awready,
   input wire logic                       wvalid,
   input wire logic                       wready,
   input wire logic [1:0]                 bresp,
   input wire logic                       bvalid,
   input wire logic                       bready,
   input wire logic [ADDR_W-1:0]          araddr,
   input wire logic                       arvalid,
   input wire logic                       arready,
   input wire logic [31:0]                rdata,
   input wire logic [1:0]                 rresp,
   input wire logic                       rvalid,
   input wire logic                       rready,
   input wire sata_err_pkg::port_events_t events,
   input wire sata_err_pkg::control_out_t control,
   input wire logic                       error_pending
);
   // Address of the read in flight, so rdata can be judged per register
   logic [ADDR_W-1:0] rd_addr;

   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rd_addr <= '0;
      else if (arvalid && arready)
         rd_addr <= araddr;
   end

   sequence wr_take;
      awvalid && awready && wvalid && wready;
   endsequence

   sequence rd_take;
      arvalid && arready;
   endsequence

   b_answer_a: assert property (wr_take |-> ##2 bvalid)
      else $error("write response late");
   r_answer_a: assert property (rd_take |=> rvalid)
      else $error("read data late");
   rd_hold_a: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   b_hold_a: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   resv_zero_a: assert property (
      rvalid && rd_addr == `OFF_ERR_STATUS
      |-> (rdata & ~`ERR_IMPL_MASK) == 32'h0000_0000)
      else $error("reserved status bit read as one");
   ctrl_write_a: assert property (
      $changed(control.value) |-> $rose(bvalid))
      else $error("control changed without write");
   ctrl_pulse_a: assert property (
      wr_take ##0 (awaddr == `OFF_CONTROL) |-> ##[2:3] control.written)
      else $error("control action pulse missing");
   pend_crc_a: assert property (events.crc_err |-> ##2 error_pending)
      else $error("crc event not recorded");
   pend_clear_a: assert property ($fell(error_pending) |-> $past(bvalid))
      else $error("flags cleared without write");
endmodule // sata_err_status_asserts

// >>> dv/sata_err_status_tb_top.sv
`timescale 1ns/1ns
`include "sata_err_params.svh"

// =============================================
// Error status register bench
module sata_err_status_tb_top;
   localparam int ADDR_W = 8;
   localparam logic [7:0] st_a = `OFF_ERR_STATUS;
   localparam logic [7:0] ct_a = `OFF_CONTROL;
   localparam logic [1:0] ok = `RESP_OKAY;
   localparam logic [1:0] slv = `RESP_SLVERR;
   logic                       aclk = 1'b0;
   logic                       aresetn = 1'b0;
   logic [7:0]                 awaddr = 8'h00;
   logic [2:0]                 awprot = 3'h0;
   logic                       awvalid = 1'b0;
   logic                       awready;
   logic [31:0]                wdata = 32'h0000_0000;
   logic [3:0]                 wstrb = 4'h0;
   logic                       wvalid = 1'b0;
   logic                       wready;
   logic [1:0]                 bresp;
   logic                       bvalid;
   logic                       bready = 1'b0;
   logic [7:0]                 araddr = 8'h00;
   logic [2:0]                 arprot = 3'h0;
   logic                       arvalid = 1'b0;
   logic                       arready;
   logic [31:0]                rdata;
   logic [1:0]                 rresp;
   logic                       rvalid;
   logic                       rready = 1'b0;
   sata_err_pkg::port_events_t events;
   sata_err_pkg::control_out_t control;
   logic                       error_pending;
   int                         errors = 0;
   int                         comparisons = 0;
   int                         pulses = 0;
   logic [31:0]                want;
   int                         st_bit [16] = '{17, 19, 20, 21, 22, 23, 24,
                                               25, 26, 26, 9, 11, 10, 8,
                                               0, 1};

   always #2 aclk = ~aclk;

   sata_err_status #(.ADDR_W(ADDR_W)) sata_err_status_inst
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .awaddr        (awaddr),
      .awprot        (awprot),
      .awvalid       (awvalid),
      .awready       (awready),
      .wdata         (wdata),
      .wstrb         (wstrb),
      .wvalid        (wvalid),
      .wready        (wready),
      .bresp         (bresp),
      .bvalid        (bvalid),
      .bready        (bready),
      .araddr        (araddr),
      .arprot        (arprot),
      .arvalid       (arvalid),
      .arready       (arready),
      .rdata         (rdata),
      .rresp         (rresp),
      .rvalid        (rvalid),
      .rready        (rready),
      .events        (events),
      .control       (control),
      .error_pending (error_pending)
   );
   port_events_model far (.aclk(aclk), .events(events));

   always @(posedge aclk)
      if (control.written === 1'b1)
         pulses++;

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      logic ta;
      logic tw;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw))
      begin
         @(posedge aclk);
         if (awvalid && awready)
         begin
            ta = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            tw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, r}, "write response");
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      chk(rdata, e, "read data");
      chk({30'h0, rresp}, {30'h0, r}, "read response");
      rready <= 1'b0;
   endtask

   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #(20000 * 4);
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(st_a, 32'h0000_0000, ok);
      rd(ct_a, 32'h0000_0004, ok);
      rd(8'h0c, 32'h0000_0000, slv);
      wr(8'h0c, 32'hffff_ffff, 4'hf, slv);
      $display("test defaults done");
      for (int i = 0; i < 16; i++)
      begin
         far.pulse(sata_err_pkg::port_events_t'(19'h1 << (15 - i)), 1);
         want = 32'h0000_0001 << st_bit[i];
         rd(st_a, want, ok);
         rd(st_a, want, ok);
         chk({31'h0, error_pending}, 32'h0000_0001, "pending set");
         wr(st_a, want, 4'hf, ok);
         rd(st_a, 32'h0000_0000, ok);
         chk({31'h0, error_pending}, 32'h0000_0000, "pending clear");
      end
      $display("test events done");
      far.pulse(sata_err_pkg::port_events_t'(19'h1020), 1);
      far.pulse(sata_err_pkg::port_events_t'(19'h4000), 1);
      wr(st_a, 32'h0000_0000, 4'hf, ok);
      rd(st_a, 32'h0028_0200, ok);
      wr(st_a, 32'hffff_ffff, 4'hc, ok);
      rd(st_a, 32'h0000_0200, ok);
      wr(st_a, 32'h0000_0200, 4'hf, ok);
      $display("test accumulate done");
      repeat (3) @(posedge aclk);
      fork
         wr(st_a, 32'h0020_0000, 4'hf, ok);
         far.pulse(sata_err_pkg::port_events_t'(19'h1000), 2);
      join
      rd(st_a, 32'h0020_0000, ok);
      wr(st_a, 32'hffff_ffff, 4'hf, ok);
      $display("test collision done");
      far.set_levels(1'b1, 1'b0);
      rd(st_a, 32'h0001_0000, ok);
      wr(st_a, 32'hffff_ffff, 4'hf, ok);
      far.set_levels(1'b0, 1'b0);
      rd(st_a, 32'h0001_0000, ok);
      wr(st_a, 32'hffff_ffff, 4'hf, ok);
      far.set_levels(1'b1, 1'b0);
      rd(st_a, 32'h0001_0002, ok);
      wr(st_a, 32'hffff_ffff, 4'hf, ok);
      $display("test phy ready done");
      far.set_levels(1'b1, 1'b1);
      far.pulse(sata_err_pkg::port_events_t'(19'h40000), 1);
      rd(st_a, 32'h0804_0000, ok);
      rd(8'h00, 32'h0000_0007, ok);
      wr(st_a, 32'h0800_0000, 4'hf, ok);
      rd(st_a, 32'h0004_0000, ok);
      wr(st_a, 32'hffff_ffff, 4'hf, ok);
      far.set_levels(1'b1, 1'b0);
      far.pulse(sata_err_pkg::port_events_t'(19'h40000), 1);
      rd(st_a, 32'h0004_0000, ok);
      wr(8'h00, 32'hffff_ffff, 4'hf, ok);
      $display("test wake done");
      wr(ct_a, 32'hdead_beef, 4'hf, ok);
      rd(ct_a, 32'hdead_beef, ok);
      wr(ct_a, 32'h0000_0011, 4'h1, ok);
      rd(ct_a, 32'hdead_be11, ok);
      chk(control.value, 32'hdead_be11, "control value");
      chk(pulses, 32'h0000_0002, "control actions");
      $display("test control done");
      far.pulse(sata_err_pkg::port_events_t'(19'h1000), 1);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(st_a, 32'h0000_0000, ok);
      rd(ct_a, 32'h0000_0004, ok);
      $display("test reset done");
      end_sim();
   end
endmodule // sata_err_status_tb_top

bind sata_err_status sata_err_status_asserts #(.ADDR_W(ADDR_W))
   sata_err_status_asserts_inst
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .awaddr        (awaddr),
      .awvalid       (awvalid),
      .awready       (awready),
      .wvalid        (wvalid),
      .wready        (wready),
      .bresp         (bresp),
      .bvalid        (bvalid),
      .bready        (bready),
      .araddr        (araddr),
      .arvalid       (arvalid),
      .arready       (arready),
      .rdata         (rdata),
      .rresp         (rresp),
      .rvalid        (rvalid),
      .rready        (rready),
      .events        (events),
      .control       (control),
      .error_pending (error_pending)
   );

// >>> rtl/sata_err_status.sv
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "sata_err_params.svh"

// Notes on behaviour
// - 32-bit register accumulates every detected error
// - Bits clear only by write or reset
// - Written ones clear unless an event sets the bit that cycle, written zeros keep
// - Diagnostic high half, classes low, reserved zero
// - Bit 27: wake while awaiting init
// - Bit 19 decode, bit 20 disparity errors
// - Bit 21: link CRC error seen
// - Bit 25: good-CRC FIS, unknown type
// - Bit 17: phy internal error
// - Bit 16: phy ready toggled either way
// - Bit 22: negative handshake on transmit
// - Bit 23: bad link state transition
// - Bit 24: transport state transition error
// - Bit 18: wake signal detected
// - Bit 26: presence change or init
// - Bit 9: persistent unrecovered error
// - Bit 11: adapter internal fault
// - Bit 0: recovered data integrity error
// - Bit 1: communication lost then regained
// - Bit 10: protocol violation detected
// - Bit 8: transient unrecovered integrity error
// - Control register 32 bits, byte strobes pick the bytes written, reads current value

module sata_err_status
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]          awaddr,
   input  wire logic [2:0]                 awprot,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [ADDR_W-1:0]          araddr,
   input  wire logic [2:0]                 arprot,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   // Port logic
   input  wire sata_err_pkg::port_events_t events,
   output sata_err_pkg::control_out_t      control,
   output logic                            error_pending
);

   // =============================================
   // Elaboration check
   generate
      if (ADDR_W < 4)
      begin : g_bad_addr
         $error("ADDR_W must be at least 4");
      end
   endgenerate

   // =============================================
   // Declarations
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_held;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              w_held;
   logic              do_write;
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic [31:0]       byte_mask;
   logic [31:0]       err_status;
   logic [31:0]       err_set;
   logic [31:0]       err_clear;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic [1:0]        next_bresp;
   logic              phy_ready_prev;
   logic              prev_valid;
   logic              phy_was_up;
   logic              phy_rdy_toggle;
   logic              phy_rdy_regained;

   assign aw_take  = awvalid && awready;
   assign w_take   = wvalid && wready;
   assign ar_take  = arvalid && arready;
   assign do_write = aw_held && w_held && !bvalid;

   // Byte strobes widen to a bit mask
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         byte_mask[i*8 +: 8] = {8{w_strb[i]}};
      end
   end

   // =============================================
   // Write address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end
      else if (aw_take)
      begin
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   // Ready stays low from capture until the response is accepted
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         awready <= 1'b0;
      else if (aw_take || aw_held || bvalid)
         awready <= 1'b0;
      else
         awready <= 1'b1;
   end

   // =============================================
   // Write data channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end
      else if (w_take)
      begin
         w_held <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wready <= 1'b0;
      else if (w_take || w_held || bvalid)
         wready <= 1'b0;
      else
         wready <= 1'b1;
   end

   // =============================================
   // Write response
   always_comb
   begin
      if (aw_addr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_ERR_STATUS >> 2))
         next_bresp = `RESP_OKAY;
      else if (aw_addr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_CONTROL >> 2))
         next_bresp = `RESP_OKAY;
      else if (aw_addr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_LINK_STATE >> 2))
         next_bresp = `RESP_OKAY;
      else
         next_bresp = `RESP_SLVERR;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp  <= next_bresp;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // =============================================
   // Phy ready tracking
   // First sample after reset only primes the history, so a port
   // that comes up ready is not mistaken for a toggle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phy_ready_prev <= 1'b0;
         prev_valid     <= 1'b0;
      end
      else
      begin
         phy_ready_prev <= events.phy_ready;
         prev_valid     <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phy_was_up <= 1'b0;
      else if (events.phy_ready)
         phy_was_up <= 1'b1;
   end

   assign phy_rdy_toggle = prev_valid &&
                           (events.phy_ready != phy_ready_prev);
   assign phy_rdy_regained = phy_rdy_toggle && events.phy_ready &&
                             phy_was_up;

   // =============================================
   // Event to bit mapping
   always_comb
   begin
      err_set = '0;
      err_set[`BIT_RECOV_DATA] = events.recovered_data;
      err_set[`BIT_RECOV_COMM] = events.recovered_comm ||
                                 phy_rdy_regained;
      err_set[`BIT_TRANSIENT] = events.transient_err;
      err_set[`BIT_PERSISTENT] = events.persistent_err;
      err_set[`BIT_PROTOCOL] = events.protocol_err;
      err_set[`BIT_INTERNAL] = events.internal_err;
      err_set[`BIT_PHY_RDY_CHG] = phy_rdy_toggle;
      err_set[`BIT_PHY_INTERNAL] = events.phy_internal_err;
      err_set[`BIT_WAKE] = events.comwake_rx;
      err_set[`BIT_DECODE] = events.decode_err;
      err_set[`BIT_DISPARITY] = events.disparity_err;
      err_set[`BIT_CRC] = events.crc_err;
      err_set[`BIT_HANDSHAKE] = events.handshake_err;
      err_set[`BIT_LINK_SEQ] = events.link_seq_err;
      err_set[`BIT_TRANSPORT] = events.transport_err;
      err_set[`BIT_UNKNOWN_FIS] = events.unknown_fis;
      err_set[`BIT_EXCHANGED] = events.presence_change ||
                                events.cominit_rx;
      err_set[`BIT_SELECTOR] = events.comwake_rx &&
                               events.host_await_cominit;
   end

   assign err_clear = (do_write &&
                       aw_addr[ADDR_W-1:2] ==
                       (ADDR_W-2)'(`OFF_ERR_STATUS >> 2)) ?
                      (w_data & byte_mask) : '0;

   // =============================================
   // Sticky bits
   // accumulating flags
   genvar b;
   generate
      for (b = 0; b < 32; b++)
      begin : g_err
         localparam logic [31:0] IMPL = `ERR_IMPL_MASK;
         localparam logic [31:0] RSTV = `ERR_RESET;
         if (IMPL[b])
         begin : g_flag
            sticky_flag
            #(
               .RESET_VAL (RSTV[b])
            )
            u_flag
            (
               .aclk    (aclk),
               .aresetn (aresetn),
               .set     (err_set[b]),
               .clear   (err_clear[b]),
               .q       (err_status[b])
            );
         end
         else
         begin : g_rsvd
            assign err_status[b] = 1'b0;
         end
      end
   endgenerate

   // =============================================
   // Control register
   // One process drives both members so the struct has a single driver
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         control.value   <= `CTRL_RESET;
         control.written <= 1'b0;
      end
      else
      begin
         control.written <= do_write && aw_addr[ADDR_W-1:2] ==
                            (ADDR_W-2)'(`OFF_CONTROL >> 2);
         if (do_write && aw_addr[ADDR_W-1:2] ==
             (ADDR_W-2)'(`OFF_CONTROL >> 2))
            control.value <= (control.value & ~byte_mask) |
                             (w_data & byte_mask);
      end
   end

   // =============================================
   // Summary output
   // Lags the status by one cycle; fine for a level signal.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         error_pending <= 1'b0;
      else
         error_pending <= |err_status;
   end

   // =============================================
   // Read decode
   // read has no side effect
   always_comb
   begin
      next_rresp = `RESP_OKAY;
      if (araddr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_ERR_STATUS >> 2))
         next_rdata = err_status;
      else if (araddr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_CONTROL >> 2))
         next_rdata = control.value;
      else if (araddr[ADDR_W-1:2] == (ADDR_W-2)'(`OFF_LINK_STATE >> 2))
         next_rdata = {29'h0, phy_was_up,
                       events.host_await_cominit, events.phy_ready};
      else
      begin
         next_rdata = 32'h0000_0000;
         next_rresp = `RESP_SLVERR;
      end
   end

   // =============================================
   // Read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid <= 1'b1;
         rdata  <= next_rdata;
         rresp  <= next_rresp;
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         arready <= 1'b0;
      else if (ar_take || (rvalid && !rready))
         arready <= 1'b0;
      else
         arready <= 1'b1;
   end

endmodule // sata_err_status

// >>> rtl/sticky_flag.sv
`timescale 1ns/1ns

// =============================================
// One write-one-to-clear sticky flag
module sticky_flag
#(
   parameter logic RESET_VAL = 1'b0
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic set,
   input  wire logic clear,
   output logic      q
);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= RESET_VAL;
      else if (set)
         q <= 1'b1;
      else if (clear)
         q <= 1'b0;
   end

endmodule // sticky_flag

// >>> shared/sata_err_params.svh
`ifndef SATA_ERR_PARAMS_SVH
`define SATA_ERR_PARAMS_SVH

// =============================================
// Register offsets (byte addresses)
`define OFF_LINK_STATE        8'h00
`define OFF_ERR_STATUS        8'h04
`define OFF_CONTROL           8'h08

// =============================================
// Error status bit positions
`define BIT_RECOV_DATA        0
`define BIT_RECOV_COMM        1
`define BIT_TRANSIENT         8
`define BIT_PERSISTENT        9
`define BIT_PROTOCOL          10
`define BIT_INTERNAL          11
`define BIT_PHY_RDY_CHG       16
`define BIT_PHY_INTERNAL      17
`define BIT_WAKE              18
`define BIT_DECODE            19
`define BIT_DISPARITY         20
`define BIT_CRC               21
`define BIT_HANDSHAKE         22
`define BIT_LINK_SEQ          23
`define BIT_TRANSPORT         24
`define BIT_UNKNOWN_FIS       25
`define BIT_EXCHANGED         26
`define BIT_SELECTOR          27

// =============================================
// Implemented bits, reset values, responses
`define ERR_IMPL_MASK         32'h0fff_0f03
`define ERR_RESET             32'h0000_0000
`define CTRL_RESET            32'h0000_0004
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// >>> shared/sata_err_pkg.sv
package sata_err_pkg;

   // =============================================
   // Events raised by phy, link and transport logic
   typedef struct packed {
      logic comwake_rx;
      logic host_await_cominit;
      logic phy_ready;
      logic phy_internal_err;
      logic decode_err;
      logic disparity_err;
      logic crc_err;
      logic handshake_err;
      logic link_seq_err;
      logic transport_err;
      logic unknown_fis;
      logic presence_change;
      logic cominit_rx;
      logic persistent_err;
      logic internal_err;
      logic protocol_err;
      logic transient_err;
      logic recovered_data;
      logic recovered_comm;
   } port_events_t;

   // =============================================
   // Control register side effects
   typedef struct packed {
      logic        written;
      logic [31:0] value;
   } control_out_t;

endpackage
